// ==== bmh_defines.vh ====
// register offsets, field positions, reset values and timing figures
// for the battery housekeeping block; included by every design file
`ifndef BMH_DEFINES_VH
`define BMH_DEFINES_VH

// wishbone byte offsets, one aligned 32-bit word each
`define BMH_REG_CTRL       8'h00
`define BMH_REG_BAL_THR    8'h04
`define BMH_REG_HEAT_ON    8'h08
`define BMH_REG_HEAT_OFF   8'h0c
`define BMH_REG_CHG_MIN    8'h10
`define BMH_REG_STATUS     8'h14
`define BMH_REG_IRQ_STAT   8'h18
`define BMH_REG_IRQ_CLR    8'h1c
`define BMH_REG_IRQ_EN     8'h20
`define BMH_REG_TLM_IDX    8'h24

// control register fields
`define BMH_CTRL_BAL_LSB   0
`define BMH_CTRL_HEAT_LSB  2
`define BMH_CTRL_SHOW_BIT  4

// mode encodings shared by balancing and heater
`define BMH_MODE_AUTO      2'h0
`define BMH_MODE_ON        2'h1
`define BMH_MODE_OFF       2'h2

// reset values of writable registers (temperatures in 0.1 degC, signed)
`define BMH_RST_CTRL       5'h00
`define BMH_RST_BAL_THR    16'h0032
`define BMH_RST_HEAT_ON    16'h000a
`define BMH_RST_HEAT_OFF   16'h0032
`define BMH_RST_CHG_MIN    16'h0000
`define BMH_RST_TLM_IDX    8'h00

// interrupt status bit positions
`define BMH_IRQ_HEAT_ON    0
`define BMH_IRQ_HEAT_UV    1
`define BMH_IRQ_CHG_BLOCK  2
`define BMH_IRQ_BUTTON     3
`define BMH_IRQ_BAL_CHG    4
`define BMH_IRQ_W          5

// telemetry index split
`define BMH_TLM_MODULE_BIT 7

// timing: figures in milliseconds, clock in kilohertz
`define BMH_CLK_KHZ        40000
`define BMH_SHOW_TIME_MS   5000
`define BMH_BLINK_HALF_MS  250

// bargraph: five leds, 20 percent each
`define BMH_LED_N          5
`define BMH_LED_STEP       7'd20

`endif

// ==== bmh_hyst.v ====
// two-threshold comparator with memory for signed 16-bit readings
// assumes synchronous reset and readings stable in the clock domain
`timescale 1ns/1ps
`include "bmh_defines.vh"

module bmh_hyst
#(
   parameter ACT_LOW = 1'b1
)
(
   input  wire               clk_i,
   input  wire               rst_i,
   input  wire signed [15:0] value_i,
   input  wire signed [15:0] lo_thr_i,
   input  wire signed [15:0] hi_thr_i,
   output reg                active_o
);

   wire below = (value_i < lo_thr_i);
   wire above = (value_i > hi_thr_i);

   // act-low: engage below lo, release above hi; else the reverse
   always @(posedge clk_i)
   begin
      if (rst_i)
         active_o <= 1'b0;
      else if (ACT_LOW ? below : above)
         active_o <= 1'b1;
      else if (ACT_LOW ? above : below)
         active_o <= 1'b0;
   end

endmodule // bmh_hyst

// ==== bmh_bargraph.v ====
// five-led state-of-charge bargraph with blinking top led
// assumes soc_i in percent (0..100) and a blink phase from the caller
`timescale 1ns/1ps
`include "bmh_defines.vh"

module bmh_bargraph
(
   input  wire                  clk_i,
   input  wire                  rst_i,
   input  wire [6:0]            soc_i,
   input  wire                  show_i,
   input  wire                  charging_i,
   input  wire                  blink_i,
   output reg  [`BMH_LED_N-1:0] led_o
);

   wire [`BMH_LED_N:0] lit;
   wire [`BMH_LED_N-1:0] next_led;

   assign lit[`BMH_LED_N] = 1'b0;

   // led i lights once soc exceeds 20*i: ceil(soc/20), capped at five
   genvar i;
   generate
      for (i = 0; i < `BMH_LED_N; i = i + 1)
      begin : g_led
         assign lit[i] = (soc_i > `BMH_LED_STEP * i);
         // top lit led blinks while charging, lower ones steady
         assign next_led[i] = show_i & lit[i]
                              & ~(charging_i & ~lit[i+1] & blink_i);
      end
   endgenerate

   // leds come out of flip-flops
   always @(posedge clk_i)
   begin
      if (rst_i)
         led_o <= {`BMH_LED_N{1'b0}};
      else
         led_o <= next_led;
   end

endmodule // bmh_bargraph

// ==== bmh_top.v ====
// battery housekeeping: balancing, heater, charge gate, bargraph,
// telemetry routing and reset gating behind a classic wishbone slave
// assumes all inputs synchronous to clk_i (40 MHz)
`timescale 1ns/1ps
`include "bmh_defines.vh"

// Summary of operation
// - command selects balancing automatic, forced on or forced off.
// - automatic balancing stops below threshold, resumes above it.
// - heater drive is protection request ORed with supervisor request.
// - automatic heater turns on below on-threshold, off above higher off-threshold.
// - heater running from cells is cut at cell undervoltage.
// - supervisor heater modes on, off, auto; auto after reset; on ignores thresholds.
// - charging is blocked while cells are below charge temperature.
// - five leds show charge 0 to 100 percent, 20 percent each.
// - button press while active lights bargraph about five seconds.
// - bargraph stays lit while charging.
// - while charging the highest lit led blinks, lower ones steady.
// - supervisor command also turns bargraph on.
// - any system inhibit suppresses the bargraph entirely.
// - external reset acts only when a powered device drives it.
// - flight-arm inhibit holds all logic in reset.
// - telemetry indices below 0x80 go to gauge, others to module.
module bmh_top
#(
   parameter [27:0] SHOW_CYCLES  = `BMH_SHOW_TIME_MS * `BMH_CLK_KHZ,
   parameter [27:0] BLINK_CYCLES = `BMH_BLINK_HALF_MS * `BMH_CLK_KHZ
)
(
   input  wire                  clk_i,
   input  wire                  rst_i,
   // wishbone classic slave
   input  wire                  wb_cyc_i,
   input  wire                  wb_stb_i,
   input  wire                  wb_we_i,
   input  wire [7:0]            wb_adr_i,
   input  wire [3:0]            wb_sel_i,
   input  wire [31:0]           wb_dat_i,
   output reg  [31:0]           wb_dat_o,
   output reg                   wb_ack_o,
   // reset sources
   input  wire                  flight_arm_inhibit_i,
   input  wire                  ext_reset_n_i,
   input  wire                  ext_reset_powered_i,
   // system and battery state
   input  wire                  sys_inhibit_i,
   input  wire [15:0]           cell_imbalance_i,
   input  wire signed [15:0]    temp_i,
   input  wire [6:0]            soc_i,
   input  wire                  charging_i,
   input  wire                  charge_req_i,
   input  wire                  cell_uv_i,
   input  wire                  ext_power_ok_i,
   input  wire                  prot_heater_req_i,
   input  wire                  button_i,
   // outputs
   output wire                  balance_en_o,
   output wire                  heater_o,
   output wire                  charge_en_o,
   output wire [`BMH_LED_N-1:0] led_o,
   output wire                  tlm_gauge_sel_o,
   output wire                  tlm_module_sel_o,
   output wire [7:0]            tlm_index_o,
   output wire                  irq_o
);

   // combined reset: own reset, flight-arm inhibit, powered external reset
   wire ext_rst = ~ext_reset_n_i & ext_reset_powered_i;
   wire srst    = rst_i | flight_arm_inhibit_i | ext_rst;

   // software registers
   reg  [1:0]             bal_mode;
   reg  [1:0]             heat_mode;
   reg  [15:0]            bal_thr;
   reg  [15:0]            heat_on_thr;
   reg  [15:0]            heat_off_thr;
   reg  [15:0]            chg_min;
   reg  [7:0]             tlm_idx;
   reg  [`BMH_IRQ_W-1:0]  irq_stat;
   reg  [`BMH_IRQ_W-1:0]  irq_en;

   // internal state
   reg                    show_cmd;
   reg                    button_q;
   reg  [27:0]            show_cnt;
   reg  [27:0]            blink_cnt;
   reg                    blink;
   reg                    heater_q;
   reg                    chg_block_q;
   reg                    bal_q;

   wire                   bal_auto_on;
   wire                   heat_auto_on;

   // bus decode
   wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // lands as ack is seen
   wire [7:0] adr   = {wb_adr_i[7:2], 2'b00};
   wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // byte-lane merge for 16-bit registers
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] dat;
      input [15:0] mask;
      begin
         merge16 = (old & ~mask) | (dat & mask);
      end
   endfunction

   // balancing: automatic uses a single threshold both ways
   bmh_hyst #(
      .ACT_LOW  (1'b0)
   ) u_bal_hyst (
      .clk_i    (clk_i),
      .rst_i    (srst),
      .value_i  (cell_imbalance_i),
      .lo_thr_i (bal_thr),
      .hi_thr_i (bal_thr),
      .active_o (bal_auto_on)
   );

   // heater: engage below on-threshold, release above off-threshold
   bmh_hyst #(
      .ACT_LOW  (1'b1)
   ) u_heat_hyst (
      .clk_i    (clk_i),
      .rst_i    (srst),
      .value_i  (temp_i),
      .lo_thr_i (heat_on_thr),
      .hi_thr_i (heat_off_thr),
      .active_o (heat_auto_on)
   );

   // balance mode selects forced or automatic operation
   assign balance_en_o = (bal_mode == `BMH_MODE_ON) |
                         ((bal_mode == `BMH_MODE_AUTO) & bal_auto_on);

   // supervisor heater request from its own mode
   wire sup_heat = (heat_mode == `BMH_MODE_ON) |
                   ((heat_mode == `BMH_MODE_AUTO) & heat_auto_on);

   // cells feeding the heater at undervoltage cut it off
   wire heat_uv_cut = cell_uv_i & ~ext_power_ok_i;
   assign heater_o  = (prot_heater_req_i | sup_heat) & ~heat_uv_cut;

   // charging refused when too cold
   wire too_cold    = temp_i < $signed(chg_min);
   assign charge_en_o = charge_req_i & ~too_cold;

   // telemetry index routing
   assign tlm_index_o      = tlm_idx;
   assign tlm_module_sel_o = tlm_idx[`BMH_TLM_MODULE_BIT];
   assign tlm_gauge_sel_o  = ~tlm_idx[`BMH_TLM_MODULE_BIT];

   // show timer: button press or command starts a five second display
   wire button_press = button_i & ~button_q;
   wire show_start   = (button_press | show_cmd) & ~sys_inhibit_i;
   wire show_timed   = (show_cnt != 28'h0000000);

   always @(posedge clk_i)
   begin
      if (srst)
      begin
         button_q <= 1'b0;
         show_cnt <= 28'h0000000;
      end
      else
      begin
         button_q <= button_i;
         if (show_start)
            show_cnt <= SHOW_CYCLES;
         else if (show_timed)
            show_cnt <= show_cnt - 28'h0000001;
      end
   end

   // blink phase generator
   always @(posedge clk_i)
   begin
      if (srst)
      begin
         blink_cnt <= 28'h0000000;
         blink     <= 1'b0;
      end
      else if (blink_cnt >= BLINK_CYCLES - 28'h0000001)
      begin
         blink_cnt <= 28'h0000000;
         blink     <= ~blink;
      end
      else
         blink_cnt <= blink_cnt + 28'h0000001;
   end

   // display on while timed or charging, never under an inhibit
   wire show = ~sys_inhibit_i & (show_timed | charging_i);

   bmh_bargraph u_bar (
      .clk_i      (clk_i),
      .rst_i      (srst),
      .soc_i      (soc_i),
      .show_i     (show),
      .charging_i (charging_i),
      .blink_i    (blink),
      .led_o      (led_o)
   );

   // event edges for the interrupt status
   wire [`BMH_IRQ_W-1:0] irq_evt;
   assign irq_evt[`BMH_IRQ_HEAT_ON]   = heater_o & ~heater_q;
   assign irq_evt[`BMH_IRQ_HEAT_UV]   = heat_uv_cut & (prot_heater_req_i | sup_heat)
                                        & heater_q;
   assign irq_evt[`BMH_IRQ_CHG_BLOCK] = charge_req_i & too_cold & ~chg_block_q;
   assign irq_evt[`BMH_IRQ_BUTTON]    = button_press;
   assign irq_evt[`BMH_IRQ_BAL_CHG]   = balance_en_o ^ bal_q;

   always @(posedge clk_i)
   begin
      if (srst)
      begin
         heater_q    <= 1'b0;
         chg_block_q <= 1'b0;
         bal_q       <= 1'b0;
      end
      else
      begin
         heater_q    <= heater_o;
         chg_block_q <= charge_req_i & too_cold;
         bal_q       <= balance_en_o;
      end
   end

   // sticky status: a new event wins over a simultaneous clear
   wire [`BMH_IRQ_W-1:0] irq_clr =
      (wr && adr == `BMH_REG_IRQ_CLR && wb_sel_i[0]) ?
      wb_dat_i[`BMH_IRQ_W-1:0] : {`BMH_IRQ_W{1'b0}};

   always @(posedge clk_i)
   begin
      if (srst)
         irq_stat <= {`BMH_IRQ_W{1'b0}};
      else
         irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
   end

   assign irq_o = |(irq_stat & irq_en);

   // register writes, byte lanes honoured
   always @(posedge clk_i)
   begin
      if (srst)
      begin
         bal_mode     <= `BMH_MODE_AUTO;
         heat_mode    <= `BMH_MODE_AUTO;
         bal_thr      <= `BMH_RST_BAL_THR;
         heat_on_thr  <= `BMH_RST_HEAT_ON;
         heat_off_thr <= `BMH_RST_HEAT_OFF;
         chg_min      <= `BMH_RST_CHG_MIN;
         tlm_idx      <= `BMH_RST_TLM_IDX;
         irq_en       <= {`BMH_IRQ_W{1'b0}};
         show_cmd     <= 1'b0;
      end
      else
      begin
         show_cmd <= 1'b0;
         if (wr)
         begin
            case (adr)
               `BMH_REG_CTRL:
               begin
                  if (wb_sel_i[0])
                  begin
                     bal_mode  <= wb_dat_i[`BMH_CTRL_BAL_LSB+1:`BMH_CTRL_BAL_LSB];
                     heat_mode <= wb_dat_i[`BMH_CTRL_HEAT_LSB+1:`BMH_CTRL_HEAT_LSB];
                     show_cmd  <= wb_dat_i[`BMH_CTRL_SHOW_BIT];
                  end
               end
               `BMH_REG_BAL_THR:
                  bal_thr <= merge16(bal_thr, wb_dat_i[15:0], wmask);
               `BMH_REG_HEAT_ON:
                  heat_on_thr <= merge16(heat_on_thr, wb_dat_i[15:0], wmask);
               `BMH_REG_HEAT_OFF:
                  heat_off_thr <= merge16(heat_off_thr, wb_dat_i[15:0], wmask);
               `BMH_REG_CHG_MIN:
                  chg_min <= merge16(chg_min, wb_dat_i[15:0], wmask);
               `BMH_REG_IRQ_EN:
               begin
                  if (wb_sel_i[0])
                     irq_en <= wb_dat_i[`BMH_IRQ_W-1:0];
               end
               `BMH_REG_TLM_IDX:
               begin
                  if (wb_sel_i[0])
                     tlm_idx <= wb_dat_i[7:0];
               end
               default:
                  tlm_idx <= tlm_idx;
            endcase
         end
      end
   end

   // read multiplexer; unmapped and write-only words read zero
   reg [31:0] next_rdata;
   always @*
   begin
      next_rdata = 32'h00000000;
      case (adr)
         `BMH_REG_CTRL:
            next_rdata = {28'h0000000, heat_mode, bal_mode};
         `BMH_REG_BAL_THR:
            next_rdata = {16'h0000, bal_thr};
         `BMH_REG_HEAT_ON:
            next_rdata = {16'h0000, heat_on_thr};
         `BMH_REG_HEAT_OFF:
            next_rdata = {16'h0000, heat_off_thr};
         `BMH_REG_CHG_MIN:
            next_rdata = {16'h0000, chg_min};
         `BMH_REG_STATUS:
            next_rdata = {9'h000, soc_i, 3'h0, led_o, 2'h0, show,
                          charge_en_o, heat_uv_cut, heater_o,
                          heat_auto_on, balance_en_o};
         `BMH_REG_IRQ_STAT:
            next_rdata = {27'h0000000, irq_stat};
         `BMH_REG_IRQ_EN:
            next_rdata = {27'h0000000, irq_en};
         `BMH_REG_TLM_IDX:
            next_rdata = {23'h000000, tlm_module_sel_o, tlm_idx};
         default:
            next_rdata = 32'h00000000;
      endcase
   end

   // one-wait-state acknowledge with registered read data
   always @(posedge clk_i)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
            wb_dat_o <= next_rdata;
      end
   end

endmodule // bmh_top

// ==== bmh_monitor.sv ====
// assertion checker for the battery housekeeping block ports
// assumes it is bound to bmh_top and sees its ports only
`timescale 1ns/1ps
module bmh_monitor
(
   input wire       clk_i,
   input wire       rst_i,
   input wire       wb_cyc_i,
   input wire       wb_stb_i,
   input wire       wb_ack_o,
   input wire       flight_arm_inhibit_i,
   input wire       ext_reset_n_i,
   input wire       ext_reset_powered_i,
   input wire       sys_inhibit_i,
   input wire [6:0] soc_i,
   input wire       charging_i,
   input wire       charge_req_i,
   input wire       cell_uv_i,
   input wire       ext_power_ok_i,
   input wire       prot_heater_req_i,
   input wire       balance_en_o,
   input wire       heater_o,
   input wire       charge_en_o,
   input wire [4:0] led_o,
   input wire       tlm_gauge_sel_o,
   input wire       tlm_module_sel_o,
   input wire [7:0] tlm_index_o,
   input wire       irq_o
);
   // lit pattern for a charge level, led i lit above 20*i percent
   function automatic [4:0] bar(input [6:0] s);
      integer i;
      for (i = 0; i < 5; i = i + 1)
         bar[i] = (s > 20 * i);
   endfunction

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // a fresh request, and charging held steady with no reset source
   sequence wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence held_charge;
      (charging_i && !sys_inhibit_i && soc_i > 7'd40 && !flight_arm_inhibit_i
       && ext_reset_n_i)[*3];
   endsequence

   chk_wb_ack_pulse: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not a single pulse after a request");
   chk_heater_or: assert property (prot_heater_req_i && !(cell_uv_i && !ext_power_ok_i) |-> heater_o)
      else $error("protection heater request not passed to heater");
   chk_uv_cut: assert property (cell_uv_i && !ext_power_ok_i |-> !heater_o)
      else $error("heater on from cells at undervoltage");
   chk_charge_gate: assert property (!charge_req_i |-> !charge_en_o)
      else $error("charge enabled without a request");
   chk_inhibit_dark: assert property ($past(sys_inhibit_i) |-> led_o == 5'h00)
      else $error("bargraph lit during inhibit");
   chk_arm_reset: assert property (flight_arm_inhibit_i |=> led_o == 5'h00 && !balance_en_o
                                   && !irq_o && tlm_gauge_sel_o)
      else $error("logic not held in reset by flight arm inhibit");
   chk_ext_reset: assert property (!ext_reset_n_i && ext_reset_powered_i
                                   |=> tlm_index_o == 8'h00 && led_o == 5'h00)
      else $error("powered external reset ignored");
   chk_tlm_split: assert property (tlm_module_sel_o == tlm_index_o[7]
                                   && tlm_gauge_sel_o != tlm_index_o[7])
      else $error("telemetry selects disagree with index");
   chk_bar_count: assert property (led_o != 5'h00 && !$past(charging_i)
                                   |-> led_o == bar($past(soc_i)))
      else $error("bargraph pattern wrong for charge level");
   chk_charge_lit: assert property (held_charge |-> led_o[0])
      else $error("bargraph dark while charging");
endmodule // bmh_monitor

// ==== bmh_sup_model.sv ====
// supervisor model: classic wishbone master and the test pushbutton
// assumes a slave that acks every request, mapped or not
`timescale 1ns/1ps
module bmh_sup_model
(
   input  wire        clk_i,
   input  wire        ack_i,
   input  wire [31:0] dat_i,
   output reg         cyc_o,
   output reg         stb_o,
   output reg         we_o,
   output reg  [7:0]  adr_o,
   output reg  [3:0]  sel_o,
   output reg  [31:0] dat_o,
   output reg         button_o
);
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hf;
      dat_o = 32'h0;
      button_o = 1'b0;
   end

   // one classic cycle, request held until ack is sampled high
   task xfer(input we, input [7:0] adr, input [31:0] dat, output [31:0] rd);
      begin
         @(posedge clk_i);
         cyc_o <= 1'b1;
         stb_o <= 1'b1;
         we_o <= we;
         adr_o <= adr;
         dat_o <= dat;
         @(posedge clk_i);
         while (ack_i !== 1'b1)
            @(posedge clk_i);
         rd = dat_i;
         cyc_o <= 1'b0;
         stb_o <= 1'b0;
         dat_o <= ~dat; // released data does not keep its last value
      end
   endtask

   // press the button for two cycles
   task press;
      begin
         @(posedge clk_i);
         button_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         button_o <= 1'b0;
      end
   endtask
endmodule // bmh_sup_model

// ==== test_bmh_top.sv ====
// self-checking bench for bmh_top driven through a supervisor model
// assumes shortened show and blink counts for simulation
`timescale 1ns/1ps
`include "bmh_defines.vh"
module test_bmh_top;
   reg               clk_i = 1'b0;
   reg               rst_i = 1'b1;
   reg               arm = 1'b0, xrst_n = 1'b1, xpow = 1'b0, inh = 1'b0;
   reg        [15:0] imb = 16'h0000;
   reg signed [15:0] temp = 16'sd30;
   reg        [6:0]  soc = 7'd0;
   reg               chg = 1'b0, creq = 1'b0, uv = 1'b0, epok = 1'b0, prot = 1'b0;
   wire              cyc, stb, we, ack, btn, bal, heat, cen, gsel, msel, irq;
   wire       [7:0]  adr, tidx;
   wire       [3:0]  sel;
   wire       [31:0] wdat, rdat;
   wire       [4:0]  led;
   reg        [31:0] rd;
   integer           err_total = 0, n_compared = 0, cycles = 0, k, ones;

   always #12.5 clk_i = ~clk_i;

   bmh_top #(.SHOW_CYCLES(28'd50), .BLINK_CYCLES(28'd4)) bmh_top_inst
   (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .flight_arm_inhibit_i(arm), .ext_reset_n_i(xrst_n), .ext_reset_powered_i(xpow),
    .sys_inhibit_i(inh), .cell_imbalance_i(imb), .temp_i(temp), .soc_i(soc),
    .charging_i(chg), .charge_req_i(creq), .cell_uv_i(uv), .ext_power_ok_i(epok),
    .prot_heater_req_i(prot), .button_i(btn), .balance_en_o(bal), .heater_o(heat),
    .charge_en_o(cen), .led_o(led), .tlm_gauge_sel_o(gsel), .tlm_module_sel_o(msel),
    .tlm_index_o(tidx), .irq_o(irq));

   bmh_sup_model sup_model
   (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .button_o(btn));

   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp)
         begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
         end
      end
   endtask

   task tick(input integer n);
      repeat (n) @(posedge clk_i);
   endtask

   task wr(input [7:0] a, input [31:0] d);
      sup_model.xfer(1'b1, a, d, rd);
   endtask

   task rc(input [7:0] a, input [31:0] e);
      begin
         sup_model.xfer(1'b0, a, 32'h0, rd);
         check(rd, e);
      end
   endtask

   // expected pattern: ceiling of charge over twenty leds, at most five
   function [31:0] bar_of(input integer s);
      integer n;
      begin
         n = (s + 19) / 20;
         if (n > 5)
            n = 5;
         bar_of = (32'h1 << n) - 32'h1;
      end
   endfunction

   task final_report;
      begin
         $display("compared %0d, mismatches %0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // cut a hang short
   always @(posedge clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 6000)
      begin
         err_total = err_total + 1;
         final_report;
      end
   end

   initial
   begin
      tick(12);
      rst_i <= 1'b0;
      // reset values, write-only and unmapped places
      rc(`BMH_REG_CTRL, 32'h0);
      rc(`BMH_REG_BAL_THR, 32'h32);
      rc(`BMH_REG_HEAT_ON, 32'ha);
      rc(`BMH_REG_HEAT_OFF, 32'h32);
      rc(`BMH_REG_CHG_MIN, 32'h0);
      wr(8'h28, 32'hffff);
      rc(8'h28, 32'h0);
      wr(`BMH_REG_IRQ_CLR, 32'h1f);
      rc(`BMH_REG_IRQ_CLR, 32'h0);
      // balancing: automatic both ways, then forced on and off
      imb <= 16'h0064;
      tick(3);
      check(bal, 32'h1);
      imb <= 16'h000a;
      tick(3);
      check(bal, 32'h0);
      wr(`BMH_REG_CTRL, 32'h1);
      tick(2);
      check(bal, 32'h1);
      imb <= 16'h0064;
      wr(`BMH_REG_CTRL, 32'h2);
      tick(2);
      check(bal, 32'h0);
      // heater: hysteresis, forced modes, protection request, undervoltage
      check(heat, 32'h0);
      temp <= 16'sd5;
      tick(3);
      check(heat, 32'h1);
      temp <= 16'sd30;
      tick(3);
      check(heat, 32'h1);
      temp <= 16'sd60;
      tick(3);
      check(heat, 32'h0);
      wr(`BMH_REG_CTRL, 32'h4);
      tick(2);
      check(heat, 32'h1);
      temp <= 16'sd5;
      wr(`BMH_REG_CTRL, 32'h8);
      tick(3);
      check(heat, 32'h0);
      prot <= 1'b1;
      tick(2);
      check(heat, 32'h1);
      uv <= 1'b1;
      tick(2);
      check(heat, 32'h0);
      epok <= 1'b1;
      tick(2);
      check(heat, 32'h1);
      prot <= 1'b0;
      wr(`BMH_REG_CTRL, 32'h0);
      // cold charge is blocked and raises a maskable interrupt
      wr(`BMH_REG_IRQ_CLR, 32'h1f);
      wr(`BMH_REG_IRQ_EN, 32'h4);
      creq <= 1'b1;
      temp <= -16'sd5;
      tick(3);
      check(cen, 32'h0);
      check(irq, 32'h1);
      wr(`BMH_REG_IRQ_EN, 32'h0);
      tick(1);
      check(irq, 32'h0);
      wr(`BMH_REG_IRQ_EN, 32'h4);
      tick(1);
      check(irq, 32'h1);
      wr(`BMH_REG_IRQ_CLR, 32'h4);
      tick(1);
      check(irq, 32'h0);
      temp <= 16'sd0;
      tick(2);
      check(cen, 32'h1);
      creq <= 1'b0;
      // bargraph by command over the whole charge range
      for (k = 0; k <= 100; k = k + 5)
      begin
         soc <= k[6:0];
         wr(`BMH_REG_CTRL, 32'h10);
         tick(3);
         check(led, bar_of(k));
      end
      // button shows about the programmed time, then goes dark
      soc <= 7'd50;
      tick(60);
      check(led, 32'h0);
      sup_model.press;
      tick(1);
      check(led, 32'h7);
      tick(40);
      check(led, 32'h7);
      tick(15);
      check(led, 32'h0);
      // starts during inhibit are dropped
      inh <= 1'b1;
      sup_model.press;
      wr(`BMH_REG_CTRL, 32'h10);
      tick(3);
      check(led, 32'h0);
      inh <= 1'b0;
      tick(3);
      check(led, 32'h0);
      // charging keeps lower leds steady and blinks the top one
      chg <= 1'b1;
      ones = 0;
      tick(3);
      for (k = 0; k < 16; k = k + 1)
      begin
         tick(1);
         check(led[1:0], 32'h3);
         check(led[4:3], 32'h0);
         ones = ones + led[2];
      end
      check(ones > 0 && ones < 16, 32'h1);
      inh <= 1'b1;
      tick(2);
      check(led, 32'h0);
      inh <= 1'b0;
      chg <= 1'b0;
      // telemetry split and reset sources
      wr(`BMH_REG_TLM_IDX, 32'h7f);
      tick(1);
      check({gsel, msel}, 32'h2);
      wr(`BMH_REG_TLM_IDX, 32'h80);
      rc(`BMH_REG_TLM_IDX, 32'h180);
      xrst_n <= 1'b0;
      tick(3);
      check(tidx, 32'h80);
      xpow <= 1'b1;
      tick(2);
      check(tidx, 32'h0);
      xrst_n <= 1'b1;
      wr(`BMH_REG_CTRL, 32'h5);
      wr(`BMH_REG_TLM_IDX, 32'h85);
      arm <= 1'b1;
      tick(3);
      check(tidx, 32'h0);
      arm <= 1'b0;
      rc(`BMH_REG_CTRL, 32'h0);
      rc(`BMH_REG_STATUS, 32'h00320007);
      rc(`BMH_REG_IRQ_STAT, 32'h11);
      final_report;
   end
endmodule // test_bmh_top

bind bmh_top bmh_monitor bmh_monitor_inst
(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
 .flight_arm_inhibit_i(flight_arm_inhibit_i), .ext_reset_n_i(ext_reset_n_i),
 .ext_reset_powered_i(ext_reset_powered_i), .sys_inhibit_i(sys_inhibit_i), .soc_i(soc_i),
 .charging_i(charging_i), .charge_req_i(charge_req_i), .cell_uv_i(cell_uv_i),
 .ext_power_ok_i(ext_power_ok_i), .prot_heater_req_i(prot_heater_req_i),
 .balance_en_o(balance_en_o), .heater_o(heater_o), .charge_en_o(charge_en_o), .led_o(led_o),
 .tlm_gauge_sel_o(tlm_gauge_sel_o), .tlm_module_sel_o(tlm_module_sel_o),
 .tlm_index_o(tlm_index_o), .irq_o(irq_o));
